// >>> pss_top.v
// Pump sleep / wake-up and auxiliary pump staging control
`timescale 1ns/1ps
`include "pss_defs.vh"
module pss_top #(
	parameter TICK_CYC = `PSS_TICK_NS / `PSS_CLK_NS
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Register port
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	// Drive speed inputs in 0.1 Hz units, and the run command
	input  wire [15:0] ref_freq,
	input  wire [15:0] out_freq,
	input  wire [15:0] high_speed,
	input  wire        run_cmd,
	// Demand from the pressure loop
	input  wire        demand_up,
	input  wire        demand_down,
	// Pump ready pins
	input  wire [5:0]  pump_ready,
	// Outputs
	output reg         motor_run_r,
	output reg         sleep_r,
	output reg         adv_sleep_r,
	output reg  [5:0]  pump_cmd_r,
	output reg  [5:0]  pump_vs_r
);
	localparam ST_IDLE  = 3'b001;
	localparam ST_RUN   = 3'b010;
	localparam ST_SLEEP = 3'b100;
	localparam SG_IDLE  = 2'b01;
	localparam SG_SWAP  = 2'b10;

	reg  [15:0] ctrl_r;
	reg  [15:0] lst_r;
	reg  [15:0] sle_r;
	reg  [15:0] lsp_r;
	reg  [15:0] aslc_r;
	reg  [15:0] asld_r;
	reg  [15:0] aslr_r;
	reg  [15:0] altw_r;
	reg  [15:0] rdyd_r;
	reg  [2:0]  st_r;
	reg  [1:0]  sg_r;
	reg  [2:0]  lead_r;
	reg  [2:0]  new_r;
	reg  [15:0] low_cnt_r;
	reg  [15:0] alt_cnt_r;
	reg  [15:0] asl_cnt_r;
	reg  [3:0]  asl_sub_r;
	reg  [21:0] tick_cnt_r;
	reg         tick_r;
	reg  [5:0]  destage_r;
	reg  [5:0]  rdy_s1_r;
	reg  [5:0]  rdy_s2_r;
	reg  [5:0]  rdy_d_r;
	wire [5:0]  avail;
	wire [5:0]  en_m;
	wire [95:0] rt_flat;
	wire [16:0] thr;
	wire        speed_mode;
	wire        low_cond;
	wire        asl_allow;
	wire        asl_cond;
	wire        alt_on;
	wire [1:0]  cyc;
	wire [2:0]  cnt;

	assign thr = {1'b0, lsp_r} + {1'b0, sle_r};
	assign speed_mode = !ctrl_r[`PSS_C_PIDCFG] || ctrl_r[`PSS_C_PIDMAN]
		|| !ctrl_r[`PSS_C_PIDCH1]; // R01
	assign low_cond = ({1'b0, ref_freq} < thr) && ({1'b0, out_freq} < thr); // R02 R04
	assign asl_allow = ctrl_r[`PSS_C_PRESS] && (ctrl_r[`PSS_C_SDM_HI:`PSS_C_SDM_LO] != 2'h0)
		&& ctrl_r[`PSS_C_ASLEN]; // R08
	assign asl_cond = asl_allow && (out_freq <= aslc_r) && (ref_freq <= aslr_r);
	// Multi drive forbids alternation, so lead stays pump 1 there
	assign alt_on = ctrl_r[`PSS_C_ALT] && !ctrl_r[`PSS_C_MULTI]; // R13 R18
	assign cyc = ctrl_r[`PSS_C_CYC_HI:`PSS_C_CYC_LO];
	// The count field holds pumps or devices depending on architecture
	assign cnt = ctrl_r[`PSS_C_CNT_HI:`PSS_C_CNT_LO]; // R12 R13

	// 0.1 s time base
	always @(posedge clk) begin
		if (rst) begin
			tick_cnt_r <= 22'h000000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == TICK_CYC[21:0] - 22'h000001) begin
			tick_cnt_r <= 22'h000000;
			tick_r <= 1'b1; // R24
		end else begin
			tick_cnt_r <= tick_cnt_r + 22'h000001;
			tick_r <= 1'b0;
		end
	end

	// Ready pins cross into clk before anything looks at them
	always @(posedge clk) begin
		if (rst) begin
			rdy_s1_r <= 6'h00;
			rdy_s2_r <= 6'h00;
			rdy_d_r <= 6'h00;
		end else begin
			rdy_s1_r <= pump_ready;
			rdy_s2_r <= rdy_s1_r;
			rdy_d_r <= rdy_s2_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `PSS_NPUMP; g = g + 1) begin : pp
			reg [15:0] hold_r;
			reg [15:0] rt_r;
			assign en_m[g] = (g < cnt) || (g == 0);
			assign avail[g] = rdy_s2_r[g] && (hold_r == 16'h0000) && en_m[g]; // R22
			assign rt_flat[g*16 +: 16] = rt_r;
			always @(posedge clk) begin
				if (rst) begin
					hold_r <= 16'h0000;
					rt_r <= 16'h0000;
				end else begin
					if ((rdy_s2_r[g] && !rdy_d_r[g]) || destage_r[g])
						hold_r <= rdyd_r; // R23
					else if (!rdy_s2_r[g])
						hold_r <= 16'h0000; // R24
					else if (tick_r && hold_r != 16'h0000)
						hold_r <= hold_r - 16'h0001;
					// Runtime saturates rather than wrapping, keeping the ranking sane
					if (tick_r && pump_cmd_r[g] && rt_r != 16'hFFFF)
						rt_r <= rt_r + 16'h0001;
				end
			end
		end
	endgenerate

	// Pick the pump to stage and the one to destage
	reg  [2:0]  st_sel;
	reg         st_ok;
	reg  [2:0]  ds_sel;
	reg         ds_ok;
	reg  [15:0] st_best;
	reg  [15:0] ds_best;
	integer     i;
	always @* begin
		st_sel = 3'h0;
		st_ok = 1'b0;
		ds_sel = 3'h0;
		ds_ok = 1'b0;
		st_best = 16'h0000;
		ds_best = 16'h0000;
		for (i = 0; i < `PSS_NPUMP; i = i + 1) begin
			if (avail[i] && !pump_cmd_r[i] && (alt_on || i != 0)) begin
				if (cyc == `PSS_CYC_RUNT) begin
					if (!st_ok || rt_flat[i*16 +: 16] < st_best) begin // R16
						st_sel = i[2:0];
						st_ok = 1'b1;
						st_best = rt_flat[i*16 +: 16];
					end
				end else if (!st_ok) begin
					st_sel = i[2:0]; // R14 R15
					st_ok = 1'b1;
				end
			end
			if (pump_cmd_r[i] && i[2:0] != lead_r) begin // R17
				if (cyc == `PSS_CYC_RUNT) begin
					if (!ds_ok || rt_flat[i*16 +: 16] > ds_best) begin // R16
						ds_sel = i[2:0];
						ds_ok = 1'b1;
						ds_best = rt_flat[i*16 +: 16];
					end
				end else if (cyc == `PSS_CYC_LIFO) begin
					ds_sel = i[2:0]; // R15
					ds_ok = 1'b1;
				end else if (!ds_ok) begin
					ds_sel = i[2:0]; // R14
					ds_ok = 1'b1;
				end
			end
		end
	end

	// Sleep and staging sequencer
	always @(posedge clk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			sg_r <= SG_IDLE;
			lead_r <= 3'h0;
			new_r <= 3'h0;
			low_cnt_r <= 16'h0000;
			alt_cnt_r <= 16'h0000;
			motor_run_r <= 1'b0;
			sleep_r <= 1'b0;
			pump_cmd_r <= 6'h00;
			pump_vs_r <= 6'h00;
			destage_r <= 6'h00;
		end else begin
			destage_r <= 6'h00;
			case (st_r)
				ST_IDLE: begin
					sleep_r <= 1'b0;
					if (run_cmd && (alt_on ? st_ok : avail[0])) begin
						// Lead pump goes first and takes the variable speed output
						lead_r <= alt_on ? st_sel : 3'h0; // R17 R18
						pump_cmd_r <= 6'h01 << (alt_on ? st_sel : 3'h0);
						pump_vs_r <= 6'h01 << (alt_on ? st_sel : 3'h0);
						motor_run_r <= 1'b1;
						st_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (low_cond && speed_mode && lst_r != 16'h0000) begin // R06
						if (tick_r)
							low_cnt_r <= low_cnt_r + 16'h0001;
					end else begin
						low_cnt_r <= 16'h0000; // R04 R24
					end
					if (!run_cmd || (low_cnt_r >= lst_r && lst_r != 16'h0000
							&& low_cond && speed_mode)) begin
						// Dropping run lets the drive use its active decel ramp
						motor_run_r <= 1'b0; // R02 R03
						sleep_r <= run_cmd;
						destage_r <= pump_cmd_r & ~(6'h01 << lead_r);
						pump_cmd_r <= 6'h00; // R17
						pump_vs_r <= 6'h00;
						low_cnt_r <= 16'h0000;
						sg_r <= SG_IDLE;
						st_r <= run_cmd ? ST_SLEEP : ST_IDLE;
					end else begin
						case (sg_r)
							SG_IDLE: begin
								if (demand_up && st_ok) begin
									if (alt_on) begin
										// Old lead stays on as a fixed speed pump
										pump_vs_r <= 6'h00; // R19
										new_r <= st_sel;
										alt_cnt_r <= 16'h0000;
										sg_r <= SG_SWAP;
									end else begin
										pump_cmd_r[st_sel] <= 1'b1; // R14 R15 R16
									end
								end else if (demand_down && ds_ok) begin
									pump_cmd_r[ds_sel] <= 1'b0; // R21
									destage_r[ds_sel] <= 1'b1; // R23
								end
							end
							SG_SWAP: begin
								if (alt_cnt_r >= altw_r) begin // R20
									lead_r <= new_r; // R19
									pump_cmd_r[new_r] <= 1'b1;
									pump_vs_r <= 6'h01 << new_r;
									sg_r <= SG_IDLE;
								end else if (tick_r) begin
									alt_cnt_r <= alt_cnt_r + 16'h0001;
								end
							end
							default: sg_r <= SG_IDLE;
						endcase
					end
				end
				ST_SLEEP: begin
					if (!run_cmd) begin
						sleep_r <= 1'b0;
						st_r <= ST_IDLE;
					end else if ({1'b0, ref_freq} > thr) begin
						sleep_r <= 1'b0; // R05
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Advanced sleep check, counted in seconds of 10 ticks
	always @(posedge clk) begin
		if (rst) begin
			asl_cnt_r <= 16'h0000;
			asl_sub_r <= 4'h0;
			adv_sleep_r <= 1'b0;
		end else if (!asl_cond || !motor_run_r) begin
			asl_cnt_r <= 16'h0000; // R24
			asl_sub_r <= 4'h0;
			adv_sleep_r <= 1'b0;
		end else begin
			if (tick_r) begin
				if ({12'h000, asl_sub_r} == `PSS_TICKS_SEC - 16'h0001) begin
					asl_sub_r <= 4'h0;
					asl_cnt_r <= asl_cnt_r + 16'h0001;
				end else begin
					asl_sub_r <= asl_sub_r + 4'h1;
				end
			end
			adv_sleep_r <= (asl_cnt_r >= asld_r); // R10
		end
	end

	// Register writes clamp LST, SLE, ASLC, ASLD and ASLR into their legal ranges; CTRL is masked to 14 bits and the rest load as written
	always @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `PSS_CTRL_RST; // R09
			lst_r <= `PSS_LST_RST; // R06
			sle_r <= `PSS_SLE_RST; // R07
			lsp_r <= 16'h0000;
			aslc_r <= 16'h0000; // R09
			asld_r <= `PSS_ASLD_RST; // R10
			aslr_r <= 16'h0000; // R11
			altw_r <= 16'h0000;
			rdyd_r <= 16'h0000;
		end else if (wr) begin
			case (addr)
				`PSS_A_CTRL: ctrl_r <= wdata & 16'h3FFF;
				`PSS_A_LST: lst_r <= (wdata > `PSS_LST_MAX) ? `PSS_LST_MAX : wdata; // R06
				`PSS_A_SLE: sle_r <= (wdata < `PSS_SLE_MIN) ? `PSS_SLE_MIN :
					((wdata > `PSS_FMAX) ? `PSS_FMAX : wdata); // R07
				`PSS_A_LSP: lsp_r <= wdata;
				`PSS_A_ASLC: aslc_r <= (wdata > high_speed) ? high_speed : wdata; // R09
				`PSS_A_ASLD: asld_r <= (wdata > `PSS_ASLD_MAX) ? `PSS_ASLD_MAX : wdata; // R10
				`PSS_A_ASLR: aslr_r <= (wdata > `PSS_ASLR_MAX) ? `PSS_ASLR_MAX : wdata; // R11
				`PSS_A_ALTW: altw_r <= wdata;
				`PSS_A_RDYD: rdyd_r <= wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge clk) begin
		if (rst || !rd) begin
			rdata <= 16'h0000;
		end else begin
			case (addr)
				`PSS_A_CTRL: rdata <= ctrl_r;
				`PSS_A_LST: rdata <= lst_r;
				`PSS_A_SLE: rdata <= (lst_r == 16'h0000) ? 16'h0000 : sle_r; // R06
				`PSS_A_LSP: rdata <= lsp_r;
				`PSS_A_ASLC: rdata <= ctrl_r[`PSS_C_ASLEN] ? aslc_r : 16'h0000; // R09
				`PSS_A_ASLD: rdata <= ctrl_r[`PSS_C_ASLEN] ? asld_r : 16'h0000;
				`PSS_A_ASLR: rdata <= ctrl_r[`PSS_C_ASLEN] ? aslr_r : 16'h0000;
				`PSS_A_ALTW: rdata <= altw_r;
				`PSS_A_RDYD: rdata <= rdyd_r;
				// Advanced sleep has its own output pin, so the status word leaves it out
				`PSS_A_STAT: rdata <= {sleep_r, lead_r, avail, pump_cmd_r};
				default: rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// >>> pss_defs.vh
// Constants for the pump sleep and staging block
// Notes on behaviour
// R01: Speed sleep applies when PID is unconfigured, manual, or not the active channel.
// R02: Stop once reference and output frequency stay below LSP plus offset for the timeout.
// R03: Sleep stop uses the deceleration ramp currently active.
// R04: Either frequency rising above LSP plus offset cancels a pending sleep.
// R05: Wake only when reference exceeds LSP plus offset and run is still commanded.
// R06: Low speed timeout in 0.1 s steps, default zero; zero disables speed sleep.
// R07: Sleep offset from 1.0 Hz to maximum frequency, default 1.0 Hz.
// R08: Advanced sleep only with pressure control and sleep detect mode not off.
// R09: Advanced sleep speed from zero to high speed, default 0.0 Hz; mode defaults off.
// R10: Advanced sleep delay in whole seconds up to 9999, default 20 s.
// R11: Advanced sleep reference check up to 599.0 Hz, default zero.
// R12: Single drive: one variable speed pump plus up to five auxiliaries, up to count.
// R13: Multiple drives: no lead alternation, pump count from number of devices.
// R14: FIFO cycling starts and stops pumps in ascending order.
// R15: LIFO cycling starts ascending and stops descending.
// R16: Runtime cycling starts least runtime first, stops most runtime first.
// R17: Lead pump starts first, stops last, stays on variable speed output.
// R18: Without alternation pump 1 is always lead; cycling applies to auxiliaries only.
// R19: Stage alternation: next staged pump becomes lead, older ones go fixed speed.
// R20: Wait the alternation wait time when moving the variable speed output.
// R21: On low demand destage fixed speed pumps in cycling mode order.
// R22: Stopped auxiliary stays unavailable until the ready delay elapses.
// R23: Ready input going active or destage makes the pump unavailable for the delay.
// R24: All delays count 0.1 s ticks and clear when the timed condition drops.
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
`define PSS_CLK_NS       50
`define PSS_TICK_NS      100000000
`define PSS_NPUMP        6
`define PSS_A_CTRL       4'h0
`define PSS_A_LST        4'h1
`define PSS_A_SLE        4'h2
`define PSS_A_LSP        4'h3
`define PSS_A_ASLC       4'h4
`define PSS_A_ASLD       4'h5
`define PSS_A_ASLR       4'h6
`define PSS_A_ALTW       4'h7
`define PSS_A_RDYD       4'h8
`define PSS_A_STAT       4'h9
`define PSS_CTRL_RST     16'h0000
`define PSS_LST_RST      16'h0000
`define PSS_LST_MAX      16'h270F
`define PSS_SLE_RST      16'h000A
`define PSS_SLE_MIN      16'h000A
`define PSS_FMAX         16'h1766
`define PSS_ASLD_RST     16'h0014
`define PSS_ASLD_MAX     16'h270F
`define PSS_ASLR_MAX     16'h1766
`define PSS_TICKS_SEC    16'h000A
`define PSS_C_PIDCFG     0
`define PSS_C_PIDMAN     1
`define PSS_C_PIDCH1     2
`define PSS_C_PRESS      3
`define PSS_C_SDM_LO     4
`define PSS_C_SDM_HI     5
`define PSS_C_ASLEN      6
`define PSS_C_MULTI      7
`define PSS_C_ALT        8
`define PSS_C_CYC_LO     9
`define PSS_C_CYC_HI     10
`define PSS_C_CNT_LO     11
`define PSS_C_CNT_HI     13
`define PSS_CYC_FIFO     2'h0
`define PSS_CYC_LIFO     2'h1
`define PSS_CYC_RUNT     2'h2
`endif

// >>> pss_top_asserts.sv
// Concurrent checks on the pump sleep and staging block ports
`timescale 1ns/1ps
module pss_top_asserts (
	// Clock and reset
	input wire        clk,
	input wire        rst,
	// Register port
	input wire        rd,
	input wire [15:0] rdata,
	// Run command and outputs
	input wire        run_cmd,
	input wire        motor_run_r,
	input wire        sleep_r,
	input wire [5:0]  pump_cmd_r,
	input wire [5:0]  pump_vs_r
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside a read reply");
	sleep_stop_a: assert property (sleep_r |-> !motor_run_r && pump_cmd_r == 6'h00)
		else $error("motor or pump running while asleep");
	sleep_entry_a: assert property ($rose(sleep_r) |-> $past(motor_run_r))
		else $error("sleep entered without running first");
	sleep_hold_a: assert property (sleep_r |=> pump_cmd_r == 6'h00)
		else $error("pump restarted straight out of sleep");
	wake_run_a: assert property ($rose(motor_run_r) |-> $past(run_cmd))
		else $error("motor started without run command");
	vs_onehot_a: assert property ($onehot0(pump_vs_r))
		else $error("more than one pump on variable speed");
	vs_cmd_a: assert property ((pump_vs_r & ~pump_cmd_r) == 6'h00)
		else $error("variable speed pump not commanded");
	stage_one_a: assert property ($countones(pump_cmd_r & ~$past(pump_cmd_r)) <= 1)
		else $error("more than one pump started in one cycle");

	cover property ($rose(sleep_r));
	cover property ($fell(sleep_r));
	cover property ($countones(pump_cmd_r) == 3);
endmodule

// >>> pss_pump_model.sv
// Behavioural motor and pump set on the far side of the block
`timescale 1ns/1ps
module pss_pump_model #(
	parameter READY = 6'h3F
) (
	// Clock
	input wire         clk,
	// Drive side
	input wire         motor_run_r,
	input wire  [15:0] ref_freq,
	// Feedback
	output reg  [15:0] out_freq,
	output wire [5:0]  pump_ready
);
	// Contactors closed, so every pump reports ready
	assign pump_ready = READY;
	initial out_freq = 16'h0000;
	// Coasts down in steps, so a stop never reads as instant
	always @(posedge clk) begin
		if (motor_run_r)
			out_freq <= ref_freq;
		else if (out_freq > 16'h000A)
			out_freq <= out_freq - 16'h000A;
		else
			out_freq <= 16'h0000;
	end
endmodule

// >>> pss_top_tb.sv
// Self-checking testbench for the pump sleep and staging block
`timescale 1ns/1ps
`include "pss_defs.vh"
module pss_top_tb;
	reg         clk;
	reg         rst;
	reg  [3:0]  addr;
	reg  [15:0] wdata;
	reg         wr;
	reg         rd;
	wire [15:0] rdata;
	reg  [15:0] ref_freq;
	wire [15:0] out_freq;
	reg  [15:0] high_speed;
	reg         run_cmd;
	reg         demand_up;
	reg         demand_down;
	wire [5:0]  pump_ready;
	wire        motor_run_r;
	wire        sleep_r;
	wire        adv_sleep_r;
	wire [5:0]  pump_cmd_r;
	wire [5:0]  pump_vs_r;
	reg  [5:0]  first;
	integer     n_mismatch;
	integer     n_checks;
	integer     m;
	integer     i;

	pss_top #(.TICK_CYC(10)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ref_freq(ref_freq), .out_freq(out_freq), .high_speed(high_speed), .run_cmd(run_cmd),
		.demand_up(demand_up), .demand_down(demand_down), .pump_ready(pump_ready), .motor_run_r(motor_run_r),
		.sleep_r(sleep_r), .adv_sleep_r(adv_sleep_r), .pump_cmd_r(pump_cmd_r), .pump_vs_r(pump_vs_r));
	pss_pump_model i_model (.clk(clk), .motor_run_r(motor_run_r), .ref_freq(ref_freq), .out_freq(out_freq),
		.pump_ready(pump_ready));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wr_reg(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk);
			addr  <= a;
			wdata <= d;
			wr    <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_chk(input [3:0] a, input [15:0] e);
		begin
			@(posedge clk);
			addr <= a;
			rd   <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(negedge clk);
			chk(rdata, e);
		end
	endtask
	task set_ref(input [15:0] v);
		begin
			@(posedge clk);
			ref_freq <= v;
		end
	endtask
	task pulse(input up);
		begin
			@(posedge clk);
			demand_up   <= up;
			demand_down <= !up;
			@(posedge clk);
			demand_up   <= 1'b0;
			demand_down <= 1'b0;
			wt(3);
		end
	endtask
	task do_reset;
		begin
			@(posedge clk);
			rst <= 1'b1;
			repeat (3) @(posedge clk);
			rst <= 1'b0;
		end
	endtask
	task finish_test;
		begin
			if (n_mismatch == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		finish_test;
	end

	initial begin
		rst = 1'b1; addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0; ref_freq = 16'h01F4;
		high_speed = 16'h1000; run_cmd = 1'b0; demand_up = 1'b0; demand_down = 1'b0;
		n_mismatch = 0; n_checks = 0;
		do_reset;
		rd_chk(`PSS_A_CTRL, `PSS_CTRL_RST);
		rd_chk(`PSS_A_LST, `PSS_LST_RST);
		rd_chk(`PSS_A_SLE, 16'h0000);
		rd_chk(`PSS_A_ASLD, 16'h0000);
		rd_chk(4'hC, 16'h0000);
		wr_reg(`PSS_A_LST, 16'hFFFF);
		rd_chk(`PSS_A_LST, `PSS_LST_MAX);
		rd_chk(`PSS_A_SLE, `PSS_SLE_RST);
		wr_reg(`PSS_A_SLE, 16'h0005);
		rd_chk(`PSS_A_SLE, `PSS_SLE_MIN);
		wr_reg(`PSS_A_SLE, 16'hFFFF);
		rd_chk(`PSS_A_SLE, `PSS_FMAX);
		wr_reg(`PSS_A_CTRL, 16'h0040);
		rd_chk(`PSS_A_ASLD, `PSS_ASLD_RST);
		rd_chk(`PSS_A_ASLC, 16'h0000);
		rd_chk(`PSS_A_ASLR, 16'h0000);
		wr_reg(`PSS_A_ASLC, 16'hFFFF);
		rd_chk(`PSS_A_ASLC, 16'h1000);
		wr_reg(`PSS_A_ASLR, 16'hFFFF);
		rd_chk(`PSS_A_ASLR, `PSS_ASLR_MAX);
		wr_reg(`PSS_A_ASLD, 16'hFFFF);
		rd_chk(`PSS_A_ASLD, `PSS_ASLD_MAX);
		// One second of verification keeps the run short
		wr_reg(`PSS_A_ASLD, 16'h0001);
		@(posedge clk);
		run_cmd <= 1'b1;
		wt(150);
		chk({15'h0000, adv_sleep_r}, 16'h0000);
		wr_reg(`PSS_A_CTRL, 16'h0058);
		wt(150);
		chk({15'h0000, adv_sleep_r}, 16'h0001);
		do_reset;
		set_ref(16'h0032);
		wr_reg(`PSS_A_LST, 16'h0004);
		wr_reg(`PSS_A_LSP, 16'h0064);
		wr_reg(`PSS_A_CTRL, 16'h0005);
		wt(80);
		chk({15'h0000, sleep_r}, 16'h0000);
		wr_reg(`PSS_A_CTRL, 16'h0007);
		for (i = 0; i < 100 && sleep_r !== 1'b1; i = i + 1) @(negedge clk);
		chk({8'h00, sleep_r, motor_run_r, pump_cmd_r}, 16'h0080);
		set_ref(16'h00C8);
		wt(10);
		chk({8'h00, sleep_r, motor_run_r, pump_cmd_r}, 16'h0041);
		// Each low spell holds three ticks, so only a missed cancel can reach the timeout
		set_ref(16'h0032);
		wt(31);
		set_ref(16'h00C8);
		wt(3);
		set_ref(16'h0032);
		wt(31);
		chk({15'h0000, sleep_r}, 16'h0000);
		for (i = 0; i < 100 && sleep_r !== 1'b1; i = i + 1) @(negedge clk);
		chk({15'h0000, sleep_r}, 16'h0001);
		@(posedge clk);
		run_cmd  <= 1'b0;
		ref_freq <= 16'h00C8;
		wt(20);
		chk({15'h0000, motor_run_r}, 16'h0000);
		@(posedge clk);
		run_cmd  <= 1'b1;
		ref_freq <= 16'h01F4;
		for (m = 0; m < 3; m = m + 1) begin
			do_reset;
			wr_reg(`PSS_A_CTRL, {2'h0, 3'h3, m[1:0], 9'h000});
			wt(20);
			chk({pump_vs_r, 4'h0, pump_cmd_r}, 16'h0401);
			pulse(1'b1);
			first = pump_cmd_r & 6'h3E;
			wt(30);
			pulse(1'b1);
			chk({10'h000, pump_cmd_r}, 16'h0007);
			if (m < 2)
				chk({10'h000, first}, 16'h0002);
			wt(30);
			pulse(1'b0);
			chk({10'h000, pump_cmd_r}, {10'h000, m == 1 ? 6'h03 : m == 0 ? 6'h05 : 6'h07 & ~first});
		end
		do_reset;
		wr_reg(`PSS_A_ALTW, 16'h0003);
		wr_reg(`PSS_A_CTRL, 16'h1900);
		wt(20);
		pulse(1'b1);
		chk({10'h000, pump_vs_r}, 16'h0000);
		wt(50);
		chk({pump_vs_r, 4'h0, pump_cmd_r}, 16'h0803);
		do_reset;
		wr_reg(`PSS_A_RDYD, 16'h0005);
		wr_reg(`PSS_A_CTRL, 16'h1800);
		wt(80);
		pulse(1'b1);
		pulse(1'b0);
		pulse(1'b1);
		chk({10'h000, pump_cmd_r}, 16'h0005);
		do_reset;
		wr_reg(`PSS_A_CTRL, 16'h1980);
		wt(20);
		pulse(1'b1);
		chk({pump_vs_r, 4'h0, pump_cmd_r}, 16'h0403);
		finish_test;
	end
endmodule

bind pss_top pss_top_asserts i_chk (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata), .run_cmd(run_cmd),
	.motor_run_r(motor_run_r), .sleep_r(sleep_r), .pump_cmd_r(pump_cmd_r), .pump_vs_r(pump_vs_r));
